// >>> hdl/mis_defs.svh
/*
 constants for the instruction execution core: flag bit positions, register map,
 reset values and field positions. assumes inclusion by bare name.
*/
`ifndef MIS_DEFS_SVH
`define MIS_DEFS_SVH
// register map, byte addresses
`define MIS_OFF_INSN   12'h000
`define MIS_OFF_ACC    12'h004
`define MIS_OFF_FLAGS  12'h008
`define MIS_OFF_PC     12'h00C
`define MIS_OFF_WDT    12'h010
`define MIS_OFF_MADDR  12'h014
`define MIS_OFF_MDATA  12'h018
`define MIS_OFF_SP     12'h01C
// instruction word fields
`define MIS_OP_HI      19
`define MIS_OP_LO      16
`define MIS_BIT_HI     14
`define MIS_BIT_LO     12
// flag bit positions in the flag register
`define MIS_F_C        0
`define MIS_F_AC       1
`define MIS_F_Z        2
`define MIS_F_OV       3
`define MIS_F_PD       4
`define MIS_F_TO       5
`define MIS_F_HALT     6
`define MIS_F_PRE1     7
`define MIS_F_PRE2     8
// numeric constants
`define MIS_BCD_MAX    4'h9
`define MIS_BCD_ADJ    4'h6
`define MIS_ZERO8      8'h00
`define MIS_ONE8       8'h01
`define MIS_PC_W       11
`define MIS_ERR_DATA   32'hDEAD_0000
`endif

// >>> hdl/mis_pkg.sv
/*
 types for the instruction execution core. assumes mis_defs.svh is visible.
*/
package mis_pkg;
	// operation codes, in the opcode field of the instruction register
	typedef enum logic [3:0] {
		MIS_OP_NOP, MIS_OP_ADC_A, MIS_OP_ADC_M, MIS_OP_ADD_A, MIS_OP_ADD_X,
		MIS_OP_ADD_M, MIS_OP_AND_A, MIS_OP_AND_X, MIS_OP_AND_M, MIS_OP_CALL,
		MIS_OP_CLR_M, MIS_OP_CLR_B, MIS_OP_WDT, MIS_OP_WDT1, MIS_OP_WDT2,
		MIS_OP_MISC
	} mis_op_e;
	// sub-code in the immediate byte when opcode is MISC
	typedef enum logic [2:0] {
		MIS_SUB_CPL, MIS_SUB_INVERT_TO_ACC, MIS_SUB_DAA, MIS_SUB_DEC, MIS_SUB_DECREMENT_TO_ACC,
		MIS_SUB_HALT, MIS_SUB_R6, MIS_SUB_R7
	} mis_sub_e;
	// status flags carried together
	typedef struct packed {
		logic halted;
		logic timeout_flag;
		logic powerdown_flag;
		logic overflow_flag;
		logic zero_flag;
		logic half_carry_flag;
		logic carry_flag;
	} mis_flags_s;
	// result of one alu evaluation
	typedef struct packed {
		logic [7:0] value;
		logic       to_acc;
		logic       to_mem;
		mis_flags_s flags;
	} mis_res_s;
endpackage

// >>> hdl/mis_core.sv
/*
 instruction execution core: software writes an instruction word over apb,
 the core executes it in one cycle against its accumulator, flags, a small
 data memory, a return stack and a watchdog counter. assumes a synchronous
 apb master on pclk and that program fetch is done by software.
*/
`timescale 1ns/1ps
`include "mis_defs.svh"
module mis_core
	import mis_pkg::*;
#(
	parameter int MEM_DEPTH = 64,
	parameter int STK_DEPTH = 6,
	parameter int WDT_W     = 8,
	parameter int PRE_W     = 7
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core status
	output logic             halted_o,
	output logic             wdt_timeout_o
);
	localparam int MAW = $clog2(MEM_DEPTH);
	localparam int SPW = $clog2(STK_DEPTH + 1);

	// state
	logic [7:0]           acc_q;
	mis_flags_s           flg_q;
	logic [`MIS_PC_W-1:0] pc_q;
	logic [WDT_W-1:0]     wdt_q;
	logic [PRE_W-1:0]     pre_q;
	logic                 pre1_q;
	logic                 pre2_q;
	logic [MAW-1:0]       maddr_q;
	logic [SPW-1:0]       sp_q;
	logic [7:0]           mem_q [MEM_DEPTH];
	logic [`MIS_PC_W-1:0] stk_q [STK_DEPTH];
	logic [31:0]          prdata_q;
	logic                 pready_q;
	logic                 pslverr_q;

	// add with carry returning 8-bit sum and flags
	function automatic mis_flags_s add_flags(input logic [7:0] a, input logic [7:0] b,
		input logic ci, input mis_flags_s f, output logic [7:0] s);
		logic [4:0] lo;
		logic [8:0] full;
		mis_flags_s r;
		lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		s    = full[7:0];
		r    = f;
		r.half_carry_flag = lo[4];
		r.carry_flag      = full[8];
		r.overflow_flag   = (a[7] == b[7]) && (s[7] != a[7]);
		r.zero_flag       = (s == `MIS_ZERO8);
		return r;
	endfunction

	// access decode
	wire       acc_phase = psel && penable;
	wire       wr_en     = acc_phase && pwrite;
	wire       rd_en     = acc_phase && !pwrite;
	wire       hit_insn  = (paddr == `MIS_OFF_INSN);
	wire       hit_acc   = (paddr == `MIS_OFF_ACC);
	wire       hit_flg   = (paddr == `MIS_OFF_FLAGS);
	wire       hit_pc    = (paddr == `MIS_OFF_PC);
	wire       hit_wdt   = (paddr == `MIS_OFF_WDT);
	wire       hit_mad   = (paddr == `MIS_OFF_MADDR);
	wire       hit_mdt   = (paddr == `MIS_OFF_MDATA);
	wire       hit_sp    = (paddr == `MIS_OFF_SP);
	wire       mapped    = hit_insn | hit_acc | hit_flg | hit_pc | hit_wdt |
	                       hit_mad | hit_mdt | hit_sp;
	// halted core refuses instructions; execution stopped until reset
	wire       exec      = wr_en && hit_insn && !flg_q.halted;
	// errors judged in the setup cycle so pslverr can stand with pready
	wire       setup     = psel && !penable;
	wire       bad       = setup && (!mapped || (pwrite && hit_insn && flg_q.halted));

	// instruction fields
	wire mis_op_e  op   = mis_op_e'(pwdata[`MIS_OP_HI:`MIS_OP_LO]);
	wire mis_sub_e sub  = mis_sub_e'(pwdata[2:0]);
	wire [7:0]     imm  = pwdata[7:0];
	wire [MAW-1:0] ea   = pwdata[8 +: MAW];
	wire [2:0]     bsel = pwdata[`MIS_BIT_HI:`MIS_BIT_LO];
	wire [`MIS_PC_W-1:0] tgt = pwdata[`MIS_PC_W-1:0];
	wire [7:0]     mv   = mem_q[ea];

	// daa nibble arithmetic
	wire       lo_adj = (acc_q[3:0] > `MIS_BCD_MAX) || flg_q.half_carry_flag;
	wire [3:0] daa_lo = lo_adj ? acc_q[3:0] + `MIS_BCD_ADJ : acc_q[3:0];
	wire       nib_c  = lo_adj ? !flg_q.half_carry_flag : 1'b0;
	wire [4:0] hi_sum = {1'b0, acc_q[7:4]} + {4'h0, nib_c};
	wire       hi_adj = (hi_sum > {1'b0, `MIS_BCD_MAX}) || flg_q.carry_flag;
	wire [3:0] daa_hi = hi_adj ? hi_sum[3:0] + `MIS_BCD_ADJ : hi_sum[3:0];

	// execute one instruction combinationally
	mis_res_s r;
	logic [7:0] sum;
	mis_flags_s af;
	always_comb begin
		af = add_flags(acc_q, (op == MIS_OP_ADD_X) ? imm : mv,
			(op == MIS_OP_ADC_A || op == MIS_OP_ADC_M) && flg_q.carry_flag, flg_q, sum);
		r.value  = `MIS_ZERO8;
		r.to_acc = 1'b0;
		r.to_mem = 1'b0;
		r.flags  = flg_q;
		unique case (op)
			MIS_OP_ADC_A, MIS_OP_ADD_A, MIS_OP_ADD_X: begin
				r.value  = sum;
				r.to_acc = 1'b1;
				r.flags  = af;
			end
			MIS_OP_ADC_M, MIS_OP_ADD_M: begin
				r.value  = sum;
				r.to_mem = 1'b1;
				r.flags  = af;
			end
			MIS_OP_AND_A, MIS_OP_AND_X, MIS_OP_AND_M: begin
				r.value  = acc_q & ((op == MIS_OP_AND_X) ? imm : mv);
				r.to_acc = (op != MIS_OP_AND_M);
				r.to_mem = (op == MIS_OP_AND_M);
				r.flags.zero_flag = (r.value == `MIS_ZERO8);
			end
			MIS_OP_CLR_M: begin
				r.value  = `MIS_ZERO8;
				r.to_mem = 1'b1;
			end
			MIS_OP_CLR_B: begin
				r.value  = mv & ~(`MIS_ONE8 << bsel);
				r.to_mem = 1'b1;
			end
			MIS_OP_MISC: begin
				unique case (sub)
					MIS_SUB_CPL, MIS_SUB_INVERT_TO_ACC: begin
						r.value  = ~mv;
						r.to_mem = (sub == MIS_SUB_CPL);
						r.to_acc = (sub == MIS_SUB_INVERT_TO_ACC);
						r.flags.zero_flag = (r.value == `MIS_ZERO8);
					end
					MIS_SUB_DEC, MIS_SUB_DECREMENT_TO_ACC: begin
						r.value  = mv - `MIS_ONE8;
						r.to_mem = (sub == MIS_SUB_DEC);
						r.to_acc = (sub == MIS_SUB_DECREMENT_TO_ACC);
						r.flags.zero_flag = (r.value == `MIS_ZERO8);
					end
					MIS_SUB_DAA: begin
						r.value  = {daa_hi, daa_lo};
						r.to_mem = 1'b1;
						r.flags.carry_flag = hi_adj ? 1'b1 : flg_q.carry_flag;
					end
					MIS_SUB_HALT: begin
						r.flags.halted         = 1'b1;
						r.flags.powerdown_flag = 1'b1;
						r.flags.timeout_flag   = 1'b0;
					end
					default: ;  // spare sub-codes act as no operation
				endcase
			end
			default: ;  // nop, call and watchdog ops handled below
		endcase
	end

	// watchdog clear decisions
	wire wdt_full  = exec && op == MIS_OP_WDT;
	wire pre_done  = exec && ((op == MIS_OP_WDT1 && pre2_q) ||
	                          (op == MIS_OP_WDT2 && pre1_q));
	wire halt_ex   = exec && op == MIS_OP_MISC && sub == MIS_SUB_HALT;
	wire wdt_clr   = wdt_full || pre_done || halt_ex;
	wire wdt_tick  = !flg_q.halted && (&pre_q);
	wire do_call   = exec && op == MIS_OP_CALL && sp_q < SPW'(STK_DEPTH);
	// a clear restarts the count, so no overflow is seen in that cycle
	wire wdt_ovf   = wdt_tick && (&wdt_q) && !wdt_clr;
	// software may load the status flags but never leave the halted state
	wire mis_flags_s flg_wr = mis_flags_s'({flg_q.halted, pwdata[`MIS_F_TO:`MIS_F_C]});

	// accumulator, pc, flags and stack pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= `MIS_ZERO8;
			pc_q  <= '0;
			flg_q <= '0;
			sp_q  <= '0;
		end else begin
			if (exec) begin
				if (r.to_acc)
					acc_q <= r.value;
				pc_q  <= do_call ? tgt : pc_q + 1'b1;
				sp_q  <= do_call ? sp_q + 1'b1 : sp_q;
				flg_q <= r.flags;
				if (wdt_full || pre_done) begin
					flg_q.timeout_flag   <= 1'b0;
					flg_q.powerdown_flag <= 1'b0;
				end
			end else begin
				if (wr_en && hit_acc)
					acc_q <= pwdata[7:0];
				if (wr_en && hit_flg)
					flg_q <= flg_wr;
			end
			// overflow wins over any flag load in the same cycle
			if (wdt_ovf)
				flg_q.timeout_flag <= 1'b1;
		end
	end

	// memory and stack writes; no reset so ram contents survive halt
	always_ff @(posedge pclk) begin
		if (exec && r.to_mem)
			mem_q[ea] <= r.value;
		else if (wr_en && hit_mdt)
			mem_q[maddr_q] <= pwdata[7:0];
		if (do_call)
			stk_q[sp_q] <= pc_q + 1'b1;
	end

	// watchdog, prescaler and preclear marks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_q  <= '0;
			pre_q  <= '0;
			pre1_q <= 1'b0;
			pre2_q <= 1'b0;
		end else begin
			pre_q  <= wdt_clr ? '0 : pre_q + PRE_W'(!flg_q.halted);
			wdt_q  <= wdt_clr ? '0 : wdt_q + WDT_W'(wdt_tick);
			pre1_q <= !pre_done && (pre1_q || (exec && op == MIS_OP_WDT1));
			pre2_q <= !pre_done && (pre2_q || (exec && op == MIS_OP_WDT2));
		end
	end

	// bus read mux and memory address register
	wire [31:0] rd_mux =
		hit_acc ? {24'h0, acc_q} :
		hit_flg ? {23'h0, pre2_q, pre1_q, flg_q} :
		hit_pc  ? {21'h0, pc_q} :
		hit_wdt ? {{(32-WDT_W){1'b0}}, wdt_q} :
		hit_mad ? {{(32-MAW){1'b0}}, maddr_q} :
		hit_mdt ? {24'h0, mem_q[maddr_q]} :
		hit_sp  ? {{(32-SPW){1'b0}}, sp_q} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			maddr_q   <= '0;
		end else begin
			pready_q  <= setup;  // answer in the first access cycle
			pslverr_q <= bad;
			prdata_q  <= (setup && !pwrite && mapped) ? rd_mux : 32'h0;
			if (wr_en && hit_mad)
				maddr_q <= pwdata[MAW-1:0];
		end
	end

	// outputs from flops
	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign halted_o      = flg_q.halted;
	assign wdt_timeout_o = flg_q.timeout_flag;

	// checks
	a_add_carry: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_ADD_X |=> flg_q.carry_flag == (({1'b0,$past(acc_q)} +
		{1'b0,$past(imm)}) > 9'h0FF)) else $error("add carry wrong");
	a_and_flags: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_AND_X |=> flg_q.carry_flag == $past(flg_q.carry_flag)
		&& acc_q == ($past(acc_q) & $past(imm))) else $error("and result wrong");
	a_halt_pd: assert property (@(posedge pclk) disable iff (!presetn)
		halt_ex |=> flg_q.powerdown_flag && !flg_q.timeout_flag && wdt_q == '0)
		else $error("halt flags wrong");
	a_halt_stays: assert property (@(posedge pclk) disable iff (!presetn)
		flg_q.halted |=> flg_q.halted && $stable(pc_q)) else $error("halt left");
	a_wdt_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wdt_full |=> wdt_q == '0 && pre_q == '0 && !flg_q.timeout_flag)
		else $error("wdt clear failed");
	a_pre_single: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_WDT1 && !pre2_q |=> pre1_q &&
		$stable(flg_q.powerdown_flag)) else $error("preclear acted alone");
	a_call_pc: assert property (@(posedge pclk) disable iff (!presetn)
		do_call |=> pc_q == $past(tgt) && sp_q == $past(sp_q) + 1'b1)
		else $error("call target wrong");
	a_dec_zero: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_MISC && sub == MIS_SUB_DECREMENT_TO_ACC |=>
		flg_q.zero_flag == ($past(mv) == `MIS_ONE8)) else $error("dec zero wrong");
	a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready) else $error("apb no answer");
	a_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !mapped |=> pslverr && pready) else $error("apb error missing");
	a_adc_mem: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_ADC_M |=> acc_q == $past(acc_q) && mem_q[$past(ea)] ==
		8'($past(acc_q) + $past(mv) + $past(flg_q.carry_flag)))
		else $error("adc to memory wrong");
	a_and_mem: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_AND_M |=> acc_q == $past(acc_q) &&
		mem_q[$past(ea)] == ($past(acc_q) & $past(mv)) &&
		flg_q.carry_flag == $past(flg_q.carry_flag)) else $error("and to memory wrong");
	a_clr_byte: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_CLR_M |=> mem_q[$past(ea)] == `MIS_ZERO8 &&
		flg_q[`MIS_F_PD:`MIS_F_C] == $past(flg_q[`MIS_F_PD:`MIS_F_C]))
		else $error("clear byte wrong");
	a_clr_bit: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_CLR_B |=> !mem_q[$past(ea)][$past(bsel)] &&
		(mem_q[$past(ea)] | (`MIS_ONE8 << $past(bsel))) ==
		($past(mv) | (`MIS_ONE8 << $past(bsel)))) else $error("clear bit wrong");
	a_invert_to_acc_zero: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_MISC && sub == MIS_SUB_INVERT_TO_ACC |=> acc_q == ~$past(mv) &&
		mem_q[$past(ea)] == $past(mv) &&
		flg_q.zero_flag == ($past(mv) == ~`MIS_ZERO8)) else $error("complement wrong");
	a_daa_carry: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_MISC && sub == MIS_SUB_DAA |=> acc_q == $past(acc_q) &&
		(flg_q.carry_flag || !$past(flg_q.carry_flag)) &&
		flg_q[`MIS_F_OV:`MIS_F_AC] == $past(flg_q[`MIS_F_OV:`MIS_F_AC]))
		else $error("daa flags wrong");
	a_dec_mem: assert property (@(posedge pclk) disable iff (!presetn)
		exec && op == MIS_OP_MISC && sub == MIS_SUB_DEC |=> acc_q == $past(acc_q) &&
		mem_q[$past(ea)] + `MIS_ONE8 == $past(mv)) else $error("decrement wrong");
	a_halt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
		flg_q.halted |=> $stable(wdt_q) && $stable(pre_q))
		else $error("halted core still counting");
	a_ovf_timeout: assert property (@(posedge pclk) disable iff (!presetn)
		wdt_ovf |=> flg_q.timeout_flag) else $error("timeout not set");
endmodule

// >>> tb/mis_ref_add.sv
/*
 reference adder for the accumulator side: sum, carry, half carry,
 signed overflow and zero of one 8-bit addition with carry in.
 assumes the bench settles its inputs before reading the outputs.
*/
`timescale 1ns/1ps
module mis_ref_add (
	// operands
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       ci,
	// result and flags
	output logic      [7:0] s,
	output logic            c,
	output logic            hc,
	output logic            ov,
	output logic            z
);
	logic [8:0] full;
	logic [4:0] low;
	// nine-bit sum keeps the carry out of bit 7
	assign full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
	assign low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
	assign s    = full[7:0];
	assign c    = full[8];
	assign hc   = low[4];
	assign ov   = (a[7] == b[7]) && (s[7] != a[7]);
	assign z    = (s == 8'h00);
endmodule

// >>> tb/mcu_instruction_semantics_a_to_d_tb_top.sv
/*
 self-checking bench for the execution core: drives apb, executes one
 instruction at a time and reads accumulator, memory and flags back.
 assumes acc, flags, maddr and mdata are writable over apb.
*/
`timescale 1ns/1ps
`include "mis_defs.svh"
module mcu_instruction_semantics_a_to_d_tb_top import mis_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, halted_o, wdt_timeout_o;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, ra, rm, rf, rx;
	logic [7:0]  ea, eb, s;
	logic        eci, c, hc, ov, z, err;
	int          fail_count, num_checks;
	mis_op_e     add_ops [5] = '{MIS_OP_ADC_A, MIS_OP_ADC_M, MIS_OP_ADD_A, MIS_OP_ADD_X, MIS_OP_ADD_M};
	logic [7:0]  av [5] = '{8'h7F, 8'hFF, 8'h08, 8'h80, 8'h3C};
	logic [7:0]  bv [5] = '{8'h00, 8'h01, 8'h08, 8'h80, 8'hC4};
	// prescaler shortened so a timeout arrives in about a thousand cycles
	mis_core #(.PRE_W(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .halted_o(halted_o), .wdt_timeout_o(wdt_timeout_o));
	mis_ref_add ref_add (.a(ea), .b(eb), .ci(eci), .s(s), .c(c), .hc(hc), .ov(ov), .z(z));
	// clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic report_and_stop();
		if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rx, err);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		apb(1'b0, a, 32'h0, r, err);
	endtask
	// preset state at memory address 5, execute, read accumulator, memory and flags back
	task automatic run(input mis_op_e op, input logic [14:0] lo, input logic [7:0] a,
			input logic [7:0] m, input logic [5:0] f);
		wr(`MIS_OFF_ACC, {24'h0, a});
		wr(`MIS_OFF_MADDR, 32'h5);
		wr(`MIS_OFF_MDATA, {24'h0, m});
		wr(`MIS_OFF_FLAGS, {26'h0, f});
		wr(`MIS_OFF_INSN, {12'h0, op, 1'b0, lo});
		rd(`MIS_OFF_ACC, ra);
		rd(`MIS_OFF_MDATA, rm);
		rd(`MIS_OFF_FLAGS, rf);
	endtask
	task automatic t_add();
		bit cy, ma;
		for (int i = 0; i < 5; i++) begin
			cy = (i < 2);
			ma = (add_ops[i] == MIS_OP_ADC_M || add_ops[i] == MIS_OP_ADD_M);
			ea = av[i]; eb = bv[i]; eci = cy;
			run(add_ops[i], {7'h05, bv[i]}, av[i], bv[i], 6'h11);
			chk(ma ? rm[7:0] : ra[7:0], s);
			chk(ma ? ra[7:0] : rm[7:0], ma ? av[i] : bv[i]);
			chk(rf[5:0], {2'b01, ov, z, hc, c});
		end
	endtask
	task automatic t_logic();
		run(MIS_OP_AND_A, 15'h0500, 8'hF0, 8'h0F, 6'h0B);
		chk({ra[7:0], rf[5:0]}, {8'h00, 6'h0F});
		run(MIS_OP_AND_X, 15'h053C, 8'hF0, 8'h0F, 6'h0F);
		chk({ra[7:0], rf[5:0]}, {8'h30, 6'h0B});
		run(MIS_OP_AND_M, 15'h0500, 8'h0E, 8'h0F, 6'h00);
		chk({ra[7:0], rm[7:0], rf[5:0]}, {8'h0E, 8'h0E, 6'h00});
		run(MIS_OP_MISC, {7'h05, 5'h0, MIS_SUB_CPL}, 8'h11, 8'hFF, 6'h0B);
		chk({ra[7:0], rm[7:0], rf[5:0]}, {8'h11, 8'h00, 6'h0F});
		run(MIS_OP_MISC, {7'h05, 5'h0, MIS_SUB_INVERT_TO_ACC}, 8'h11, 8'h0F, 6'h0F);
		chk({ra[7:0], rm[7:0], rf[5:0]}, {8'hF0, 8'h0F, 6'h0B});
		run(MIS_OP_MISC, {7'h05, 5'h0, MIS_SUB_DEC}, 8'h11, 8'h01, 6'h00);
		chk({ra[7:0], rm[7:0], rf[5:0]}, {8'h11, 8'h00, 6'h04});
		run(MIS_OP_MISC, {7'h05, 5'h0, MIS_SUB_DECREMENT_TO_ACC}, 8'h11, 8'h00, 6'h04);
		chk({ra[7:0], rm[7:0], rf[5:0]}, {8'hFF, 8'h00, 6'h00});
	endtask
	task automatic t_misc();
		run(MIS_OP_CLR_M, 15'h0500, 8'h22, 8'hA5, 6'h0F);
		chk({ra[7:0], rm[7:0], rf[5:0]}, {8'h22, 8'h00, 6'h0F});
		run(MIS_OP_CLR_B, 15'h4500, 8'h22, 8'hFF, 6'h00);
		chk({rm[7:0], rf[5:0]}, {8'hEF, 6'h00});
		// low nibble A and high 9 both overflow, carry out set
		run(MIS_OP_MISC, {7'h05, 5'h0, MIS_SUB_DAA}, 8'h9A, 8'h77, 6'h00);
		chk({ra[7:0], rm[7:0], rf[5:0]}, {8'h9A, 8'h00, 6'h01});
		run(MIS_OP_MISC, {7'h05, 5'h0, MIS_SUB_DAA}, 8'h34, 8'h77, 6'h0E);
		chk({rm[7:0], rf[5:0]}, {8'h3A, 6'h0E});
		rd(`MIS_OFF_SP, rx);
		ea = rx[7:0];
		run(MIS_OP_CALL, 15'h005A, 8'h22, 8'h00, 6'h0F);
		rd(`MIS_OFF_PC, rx);
		chk({rx[10:0], rf[5:0]}, {11'h05A, 6'h0F});
		rd(`MIS_OFF_SP, rx);
		chk(rx[7:0], ea + 8'h01);
	endtask
	task automatic t_wdt();
		wr(`MIS_OFF_FLAGS, 32'h30);
		wr(`MIS_OFF_INSN, {12'h0, MIS_OP_WDT1, 16'h0});
		rd(`MIS_OFF_FLAGS, rf);
		chk({rf[`MIS_F_PRE1], rf[5:4]}, 3'b111);
		wr(`MIS_OFF_INSN, {12'h0, MIS_OP_WDT2, 16'h0});
		rd(`MIS_OFF_FLAGS, rf);
		rd(`MIS_OFF_WDT, rx);
		chk({rf[5:4], 1'b0, rx[7:2]}, 9'h000);
		for (int n = 0; n < 2000 && wdt_timeout_o !== 1'b1; n++) @(posedge pclk);
		chk(wdt_timeout_o, 1'b1);
		wr(`MIS_OFF_INSN, {12'h0, MIS_OP_WDT, 16'h0});
		rd(`MIS_OFF_FLAGS, rf);
		rd(`MIS_OFF_WDT, rx);
		chk({wdt_timeout_o, rf[5:4], rx[7:2]}, 9'h000);
	endtask
	task automatic t_halt();
		wr(`MIS_OFF_FLAGS, 32'h20);
		wr(`MIS_OFF_INSN, {12'h0, MIS_OP_MISC, 16'h0005});
		rd(`MIS_OFF_FLAGS, rf);
		chk({halted_o, rf[5:4]}, 3'b101);
		rd(`MIS_OFF_WDT, rx);
		chk(rx[7:2], 6'h00);
		wr(`MIS_OFF_INSN, {12'h0, MIS_OP_ADD_X, 16'h0001});
		chk(err, 1'b1);
		apb(1'b0, 12'h020, 32'h0, rx, err);
		chk(err, 1'b1);
		chk(rx, 32'h0);
	endtask
	// main sequence
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; fail_count = 0; num_checks = 0;
		ea = 8'h00; eb = 8'h00; eci = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_add();
		t_logic();
		t_misc();
		t_wdt();
		t_halt();
		report_and_stop();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		report_and_stop();
	end
endmodule
